//--- amd_cfg.svh
`ifndef AMD_CFG_SVH
`define AMD_CFG_SVH
// Core and bus widths
`define AMD_CORE_AW 20
`define AMD_BUS_AW 24
`define AMD_DW 16
`define AMD_EXT_AW 18
// Inaccessible span bounds
`define AMD_HOLE_LO 24'h080000
`define AMD_HOLE_HI 24'hF7FFFF
// Module register block: 4 KB window at nibble M111 in bits 23:20 region of bits 19:12
`define AMD_REG_NIB 3'h7
`define AMD_REG_BLK_HI 8'hFF
// Boot ROM: 512 bytes at the bottom of the map
`define AMD_ROM_BASE 24'h000000
`define AMD_ROM_BYTES 24'h000200
// Number of implemented module slots in the register block
`define AMD_NSLOT 4
`endif

//--- amd_pkg.sv
package amd_pkg;
  typedef enum logic [3:0] {
    AMD_TGT_NONE = 4'h1,
    AMD_TGT_MOD = 4'h2,
    AMD_TGT_ROM = 4'h4,
    AMD_TGT_EXT = 4'h8
  } amd_tgt_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [19:0] addr;
    logic [15:0] wdata;
  } amd_core_req_t;
  typedef struct packed {
    logic valid;
    logic write;
    logic [23:0] addr;
    logic [15:0] wdata;
  } amd_bus_req_t;
  typedef struct packed {
    logic [23:0] bus_addr;
    logic bus_valid;
    logic bus_write;
    logic [15:0] bus_wdata;
    amd_tgt_t tgt;
    logic [3:0] mod_sel;
    logic [17:0] ext_addr;
    logic ext_sel;
    logic rom_sel;
    logic hole;
    logic rom_en;
    logic map_m;
    logic cfg_done;
  } amd_state_t;
endpackage

//--- amd_slot_match.sv
`timescale 1ns/1ns
`include "amd_cfg.svh"
module amd_slot_match #(
  parameter logic [3:0] SLOT = 4'h0,
  parameter logic SLOT_PRESENT = 1'b1
) (
  input wire logic [23:0] addr,
  input wire logic blk_hit,
  output logic hit
);
  // Slot is the 1 KB page within the 4 KB register block
  assign hit = blk_hit && SLOT_PRESENT && (addr[11:10] == SLOT[1:0]);
endmodule // amd_slot_match

//--- amd_decoder.sv
`timescale 1ns/1ns
`include "amd_cfg.svh"
module amd_decoder #(
  parameter logic [`AMD_NSLOT-1:0] SLOT_PRESENT = 4'hF
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire amd_pkg::amd_core_req_t core_req,
  input wire logic rom_enable_strap,
  input wire logic module_map_select,
  output amd_pkg::amd_bus_req_t shared_module_interconnect,
  output amd_pkg::amd_tgt_t tgt,
  output logic [`AMD_NSLOT-1:0] mod_sel,
  output logic rom_sel,
  output logic ext_sel,
  output logic [`AMD_EXT_AW-1:0] ext_addr,
  output logic hole_access
);
  // ----------------------------------------
  // State
  // ----------------------------------------
  amd_pkg::amd_state_t s_q;
  amd_pkg::amd_state_t s_d;
  logic core_valid;
  logic core_write;
  logic [`AMD_CORE_AW-1:0] core_addr;
  logic [`AMD_DW-1:0] core_wdata;
  logic [`AMD_BUS_AW-`AMD_CORE_AW-1:0] upper_bits;
  logic [`AMD_BUS_AW-1:0] full_addr;
  logic above_hole_lo;
  logic below_hole_hi;
  logic in_hole;
  logic blk_nib_hit;
  logic blk_page_hit;
  logic blk_hit;
  logic below_rom_top;
  logic in_rom;
  logic rom_read;
  logic any_slot;
  logic [`AMD_NSLOT-1:0] slot_hit;
  logic [3:0] route_pick;
  logic cfg_first;
  logic rom_en_next;

  // Map seen from the core, after extension:
  //   000000-0001FF  boot ROM, reads only, when enabled at reset
  //   080000-F7FFFF  nothing answers
  //   FFF000-FFFFFF  4 KB module register block, four 1 KB slots, only while M=1
  //   anything else  external bus, low 18 bits on the pins

  // ----------------------------------------
  // Core request fields
  // ----------------------------------------
  // Field aliases keep the decode below readable
  assign core_valid = core_req.valid;
  assign core_write = core_req.write;
  assign core_addr = core_req.addr;
  assign core_wdata = core_req.wdata;

  // ----------------------------------------
  // Address extension
  // ----------------------------------------
  // Sign-extend so the core's 1 MB space folds onto both ends of the 16 MB map
  assign upper_bits = {(`AMD_BUS_AW-`AMD_CORE_AW){core_addr[`AMD_CORE_AW-1]}};
  assign full_addr = {upper_bits, core_addr};

  // ----------------------------------------
  // Range checks
  // ----------------------------------------
  assign above_hole_lo = (full_addr >= `AMD_HOLE_LO);
  assign below_hole_hi = (full_addr <= `AMD_HOLE_HI);
  assign in_hole = above_hole_lo && below_hole_hi;
  // Map bit acts one edge after the pin moves, so a map change lands next cycle
  assign blk_nib_hit = (full_addr[23:20] == {s_q.map_m, `AMD_REG_NIB});
  assign blk_page_hit = (full_addr[19:12] == `AMD_REG_BLK_HI);
  assign blk_hit = blk_nib_hit && blk_page_hit;
  // ROM enable is only valid from the second edge after reset; earlier reads go out
  assign below_rom_top = (full_addr < (`AMD_ROM_BASE + `AMD_ROM_BYTES));
  assign in_rom = s_q.rom_en && below_rom_top;
  assign rom_read = in_rom && !core_write;

  // ----------------------------------------
  // Module slots
  // ----------------------------------------
  // Absent slots never match, so those pages fall through to the external bus
  genvar g;
  generate
    for (g = 0; g < `AMD_NSLOT; g++) begin : g_slot
      amd_slot_match #(
        .SLOT(4'(g)),
        .SLOT_PRESENT(SLOT_PRESENT[g])
      ) u_slot (
        .addr(full_addr),
        .blk_hit(blk_hit),
        .hit(slot_hit[g])
      );
    end
  endgenerate
  assign any_slot = |slot_hit;

  // ----------------------------------------
  // Route priority
  // ----------------------------------------
  // One-hot pick: hole, module, boot ROM, external; modules outrank the ROM
  assign route_pick[3] = core_valid && in_hole;
  assign route_pick[2] = core_valid && !in_hole && any_slot;
  assign route_pick[1] = core_valid && !in_hole && !any_slot && rom_read;
  assign route_pick[0] = core_valid && !in_hole && !any_slot && !rom_read;

  // ----------------------------------------
  // Boot configuration
  // ----------------------------------------
  // Strap is taken on the first edge after reset and then held for the run
  assign cfg_first = !s_q.cfg_done;
  assign rom_en_next = cfg_first ? rom_enable_strap : s_q.rom_en;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.map_m = module_map_select;
    s_d.rom_en = rom_en_next;
    s_d.cfg_done = 1'b1;

    // Bus fields follow the core every cycle, valid or not
    s_d.bus_valid = core_valid;
    s_d.bus_write = core_write;
    s_d.bus_wdata = core_wdata;
    s_d.bus_addr = full_addr;
    s_d.ext_addr = full_addr[`AMD_EXT_AW-1:0];

    case (route_pick)
      4'b1000: begin
        // No target is selected; the decoder raises hole_access and still passes valid to the bus
        s_d.mod_sel = '0;
        s_d.rom_sel = 1'b0;
        s_d.ext_sel = 1'b0;
        s_d.hole = 1'b1;
        s_d.tgt = amd_pkg::AMD_TGT_NONE;
      end
      4'b0100: begin
        s_d.mod_sel = slot_hit;
        s_d.rom_sel = 1'b0;
        s_d.ext_sel = 1'b0;
        s_d.hole = 1'b0;
        s_d.tgt = amd_pkg::AMD_TGT_MOD;
      end
      4'b0010: begin
        s_d.mod_sel = '0;
        s_d.rom_sel = 1'b1;
        s_d.ext_sel = 1'b0;
        s_d.hole = 1'b0;
        s_d.tgt = amd_pkg::AMD_TGT_ROM;
      end
      4'b0001: begin
        s_d.mod_sel = '0;
        s_d.rom_sel = 1'b0;
        s_d.ext_sel = 1'b1;
        s_d.hole = 1'b0;
        s_d.tgt = amd_pkg::AMD_TGT_EXT;
      end
      default: begin
        // Idle cycle: nothing selected
        s_d.mod_sel = '0;
        s_d.rom_sel = 1'b0;
        s_d.ext_sel = 1'b0;
        s_d.hole = 1'b0;
        s_d.tgt = amd_pkg::AMD_TGT_NONE;
      end
    endcase
  end

  // Plain static flops: no state depends on clock rate, so rate changes are safe
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_q.bus_addr <= '0;
      s_q.bus_valid <= 1'b0;
      s_q.bus_write <= 1'b0;
      s_q.bus_wdata <= '0;
      s_q.tgt <= amd_pkg::AMD_TGT_NONE;
      s_q.mod_sel <= '0;
      s_q.ext_addr <= '0;
      s_q.ext_sel <= 1'b0;
      s_q.rom_sel <= 1'b0;
      s_q.hole <= 1'b0;
      s_q.rom_en <= 1'b0;
      s_q.map_m <= 1'b0;
      s_q.cfg_done <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output is a flop, so downstream selects never glitch
  assign shared_module_interconnect = '{
    valid: s_q.bus_valid,
    write: s_q.bus_write,
    addr: s_q.bus_addr,
    wdata: s_q.bus_wdata
  };
  assign tgt = s_q.tgt;
  assign mod_sel = s_q.mod_sel;
  assign rom_sel = s_q.rom_sel;
  assign ext_sel = s_q.ext_sel;
  assign ext_addr = s_q.ext_addr;
  assign hole_access = s_q.hole;
endmodule // amd_decoder

//--- amd_decoder_monitor.sv
`timescale 1ns/1ns
module amd_decoder_monitor #(parameter logic [3:0] SLOT_PRESENT = 4'hF) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire amd_pkg::amd_core_req_t core_req,
  input wire logic rom_enable_strap,
  input wire logic module_map_select,
  input wire amd_pkg::amd_bus_req_t shared_module_interconnect,
  input wire amd_pkg::amd_tgt_t tgt,
  input wire logic [3:0] mod_sel,
  input wire logic rom_sel,
  input wire logic ext_sel,
  input wire logic [17:0] ext_addr,
  input wire logic hole_access
);
  wire v = core_req.valid;
  wire [23:0] x = {{4{core_req.addr[19]}}, core_req.addr};
  logic rom_q, done_q, mm_q;
  // Map bit acts one edge late in the decoder, so the model keeps the same lag
  wire hit = v && x[23:12] == {mm_q, 11'h7FF};
  wire on = hit && SLOT_PRESENT[x[11:10]];
  // Strap is taken once, so later strap motion must not move the ROM
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) {rom_q, done_q, mm_q} <= 3'h0;
    else begin
      mm_q <= module_map_select;
      if (!done_q) {rom_q, done_q} <= {rom_enable_strap, 1'h1};
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!reset_n);
  chk_addr_extend: assert property (v |=>
    shared_module_interconnect.addr == $past(x)) else $error("bus addr");
  chk_pin_addr: assert property (v |=> ext_addr == $past(x[17:0])) else $error("pin");
  chk_core_data: assert property (v |=> shared_module_interconnect.wdata ==
    $past(core_req.wdata)) else $error("wdata");
  chk_hole_span: assert property (v |=> hole_access ==
    $past(x >= 24'h080000 && x <= 24'hF7FFFF)) else $error("hole");
  chk_hole_quiet: assert property (hole_access |->
    !(ext_sel || rom_sel || |mod_sel)) else $error("hole sel");
  chk_reg_base: assert property (on |=> tgt == amd_pkg::AMD_TGT_MOD &&
    mod_sel == $past(4'h1 << x[11:10])) else $error("mod");
  chk_absent_ext: assert property (hit && !on |=> ext_sel && !mod_sel) else $error("ext");
  chk_rom_strap: assert property (v && !core_req.write && x < 24'h200 |=>
    rom_sel == rom_q) else $error("rom");
  cover property (on ##1 tgt == amd_pkg::AMD_TGT_MOD);
  cover property (rom_sel);
  cover property (hit && !on);
endmodule // amd_decoder_monitor

//--- amd_far.sv
`timescale 1ns/1ns
module amd_far (
  input wire logic mclk,
  input wire logic [3:0] mod_sel,
  input wire logic rom_sel,
  input wire logic ext_sel,
  output logic [15:0] rdata = 16'h0
);
  // Unselected, the data inverts every cycle, so a stale word comes back on every second idle cycle
  always @(posedge mclk) rdata <= (|mod_sel || rom_sel || ext_sel) ? 16'hC0DE : ~rdata;
endmodule // amd_far

//--- test_amd_decoder.sv
`timescale 1ns/1ns
module test_amd_decoder;
  logic mclk = 0, reset_n = 0, strap = 1, mm = 1;
  amd_pkg::amd_core_req_t req = '0;
  amd_pkg::amd_bus_req_t smi;
  amd_pkg::amd_tgt_t tgt;
  logic [3:0] ms;
  logic rs_l, es, ho;
  logic [17:0] ea;
  logic [15:0] rd;
  logic [31:0] rs = 32'hAE2E;
  int num_errors = 0, total_checks = 0, cyc = 0;
  logic [19:0] cn [5] = '{20'hFF000, 20'hFF400, 20'hFF800, 20'hFFC00, 20'h001FF};
  amd_decoder #(.SLOT_PRESENT(4'hB)) DUT (.mclk, .reset_n, .core_req(req),
    .rom_enable_strap(strap), .module_map_select(mm), .shared_module_interconnect(smi),
    .tgt, .mod_sel(ms), .rom_sel(rs_l), .ext_sel(es), .ext_addr(ea), .hole_access(ho));
  amd_far far (.mclk, .mod_sel(ms), .rom_sel(rs_l), .ext_sel(es), .rdata(rd));
  function automatic logic [31:0] xs(logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction
  function automatic logic [3:0] want(logic [19:0] a, logic w);
    if ({{4{a[19]}}, a[19:12]} == {mm, 11'h7FF}) return a[11:10] == 2'h2 ? 4'h8 : 4'h2;
    return (a < 20'h200 && !w && strap) ? 4'h4 : 4'h8;
  endfunction
  task automatic chk(string n, logic [23:0] e, logic [23:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic go(logic [19:0] a, logic w);
    logic [3:0] t;
    t = want(a, w);
    @(posedge mclk) #1;
    req <= '{1'h1, w, a, ~a[15:0]};
    @(posedge mclk) #1;
    chk("tgt", t, tgt);
    chk("sel", {t[1], t[2], t[3]}, {|ms, rs_l, es});
    chk("slot", t[1] ? 4'h1 << a[11:10] : 4'h0, ms);
    chk("hole", 1'b0, ho);
    chk("pins", a[17:0], ea);
    chk("bus", {{4{a[19]}}, a}, smi.addr);
    chk("ctl", {w, 1'b1, ~a[15:0]}, {smi.write, smi.valid, smi.wdata});
    req.valid <= 0;
    @(posedge mclk) #1;
    chk("reply", 16'hC0DE, rd);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial forever #2 mclk = ~mclk;
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 1000) begin
      num_errors++;
      complete_run;
    end
  end
  initial begin
    repeat (16) @(posedge mclk);
    #1 reset_n = 1;
    for (int i = 0; i < 50; i++) begin
      rs = xs(rs);
      go(i < 5 ? cn[i] : rs[19:0], rs[20] & (i > 4));
    end
    go(20'h00100, 1);
    mm = 0;
    go(20'hFF000, 0);
    $display("test map done");
    reset_n = 0;
    strap = 0;
    repeat (2) @(posedge mclk);
    #1 reset_n = 1;
    go(20'h00100, 0);
    $display("test strap done");
    complete_run;
  end
endmodule // test_amd_decoder
bind amd_decoder amd_decoder_monitor #(.SLOT_PRESENT(SLOT_PRESENT)) u_mon (
  .mclk(mclk), .reset_n(reset_n), .core_req(core_req),
  .rom_enable_strap(rom_enable_strap), .module_map_select(module_map_select),
  .shared_module_interconnect(shared_module_interconnect),
  .tgt(tgt), .mod_sel(mod_sel), .rom_sel(rom_sel), .ext_sel(ext_sel),
  .ext_addr(ext_addr), .hole_access(hole_access));
